// *** ulm_params.svh ***
/*
 * Constants of the ULPI alternate-mode pin logic: control bit positions,
 * register offsets, reset values and timing counts.
 * Assumes it is included by the mode controller only.
 */
// Summary of operation
// R01 - Link writes six-pin serial select to enter six-pin serial mode.
// R02 - Stop from the link ends serial modes; device returns to synchronous mapping.
// R03 - Link sets clock keep running before entering a serial mode if needed.
// R04 - Six-pin serial mode is refused while the 4-bit double-data-rate bus is used.
// R05 - Six-pin mode inputs: transmit enable DATA0, diff data DATA1, SE0 DATA2.
// R06 - Six-pin mode outputs: DP on DATA4, DM on DATA5, diff on DATA6, DATA7 low.
// R07 - DATA3 carries a latched active-high interrupt in all serial and UART modes.
// R08 - Link writes three-pin serial select to enter three-pin serial mode.
// R09 - Three-pin DATA1 is bidirectional diff data, direction set by transmit enable.
// R10 - Three-pin DATA2 is bidirectional SE0, direction set by transmit enable.
// R11 - Three-pin and UART modes hold DATA7 to DATA4 low.
// R12 - UART passes DATA0 to DM and DP to DATA1, holds DATA2 low.
// R13 - Link should use low-speed transceiver below 921 kbit/s.
// R14 - Link prepares transceiver select, clears pulldowns and termination select.
// R15 - Link sets both UART path enables in one register write.
// R16 - UART entered once mode select and both path enables are one, any order.
// R17 - Device drives the data bus five cycles starting one clock after DIR rises.
// R18 - After that period the UART buffers are enabled and UART mode is active.
// R19 - Interface clock stops in UART mode unless keep running was set before.
// R20 - Stop or a long chip-select drop then rise exits UART mode.
// R21 - Link answers a high interrupt line by asserting stop, then reads latch.
// R22 - No car-kit interrupt registers; those offsets read zero.
// R23 - DIR stays asserted throughout low-power, serial and UART modes.
// R24 - Held stop wakes the device back to synchronous mode.
// R25 - DIR falls only after the interface clock runs again on exit.
//
`ifndef ULM_PARAMS_SVH
`define ULM_PARAMS_SVH

`define ULM_OFS_CTRL        12'h000
`define ULM_OFS_STATUS      12'h004
`define ULM_OFS_INT_LATCH   12'h008
`define ULM_OFS_INT_MASK    12'h00C
`define ULM_OFS_CARKIT_INT  12'h010

`define ULM_CTRL_SIX_PIN    0
`define ULM_CTRL_THREE_PIN  1
`define ULM_CTRL_KEEP_CLK   2
`define ULM_CTRL_UART_MODE  3
`define ULM_CTRL_TX_PATH    4
`define ULM_CTRL_RX_PATH    5
`define ULM_CTRL_DDR4       6

`define ULM_CTRL_RESET      32'h0000_0000
`define ULM_MASK_RESET      32'h0000_0000

`define ULM_CLK_MHZ         20
`define ULM_UART_DRIVE_CYC  5
`define ULM_CLK_WAKE_NS     200
`define ULM_CLK_WAKE_CYC    ((`ULM_CLK_WAKE_NS * `ULM_CLK_MHZ + 999) / 1000)
`define ULM_PWRDN_US        1000
`define ULM_PWRDN_CYC       (`ULM_PWRDN_US * `ULM_CLK_MHZ)

`endif

// *** ulm_pkg.sv ***
/*
 * Types shared by the alternate-mode pin logic.
 * Assumes the parameter header is available on the include path.
 */
package ulm_pkg;

   // ************************************************************
   // Mode and pin types
   // ************************************************************
   typedef enum logic [2:0] {
      ULM_SYNC,
      ULM_SIX_PIN,
      ULM_THREE_PIN,
      ULM_UART_DRIVE,
      ULM_UART,
      ULM_WAKE
   } ulm_mode_t;

   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
   } ulm_bus_t;

   typedef struct packed {
      logic plus_level;
      logic minus_level;
      logic diff_level;
   } ulm_line_rx_t;

endpackage : ulm_pkg

// *** ulm_alt_modes.sv ***
/*
 * Alternate data-bus modes of the ULPI transceiver: six-pin and three-pin
 * serial, transparent UART, entry, exit, DIR and interface clock control.
 * Assumes an APB master on pclk, synchronous inputs, and that the
 * synchronous-mode logic owns the bus while sync_mode is high.
 */
`timescale 1ns/1ps
`include "ulm_params.svh"

module ulm_alt_modes
   import ulm_pkg::*;
#(
   parameter int PWRDN_CYC = `ULM_PWRDN_CYC
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         clk_en,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         stp,
   input  wire logic         chip_select,
   input  wire logic [7:0]   data_in,
   output ulm_bus_t          data_bus,
   output logic              dir,
   output logic              clk_run,
   output logic              sync_mode,
   output logic              uart_buf_en,
   input  wire ulm_line_rx_t line_rx,
   input  wire logic [7:0]   int_events,
   output logic              tx_enable,
   output logic              tx_diff_data,
   output logic              serial_tx_single_ended_zero,
   output logic              uart_dm_out
);

   // ************************************************************
   // Register file
   // ************************************************************
   logic [31:0] ctrl_ff;
   logic [7:0]  int_mask_ff;
   logic [7:0]  int_latch_ff;
   ulm_mode_t   mode_ff;
   logic [2:0]  drive_cnt_ff;
   logic [3:0]  wake_cnt_ff;
   logic [31:0] cs_low_cnt_ff;
   logic        cs_long_ff;
   logic        int_line_ff;
   ulm_bus_t    nxt_bus;

   wire logic wr_acc   = psel && penable && pwrite;
   wire logic rd_acc   = psel && penable && !pwrite;
   wire logic mapped   = (paddr == `ULM_OFS_CTRL) || (paddr == `ULM_OFS_STATUS) ||
                         (paddr == `ULM_OFS_INT_LATCH) || (paddr == `ULM_OFS_INT_MASK) ||
                         (paddr == `ULM_OFS_CARKIT_INT);
   wire logic latch_rd = rd_acc && clk_en && (paddr == `ULM_OFS_INT_LATCH);
   wire logic por      = cs_long_ff && chip_select;
   wire logic in_alt   = (mode_ff != ULM_SYNC);

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Control bits; a long chip-select drop followed by a rise acts as a power-on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= `ULM_CTRL_RESET;
         int_mask_ff <= 8'h00;
      end else if (clk_en) begin
         if (por) begin                                                       // R20
            ctrl_ff     <= `ULM_CTRL_RESET;
            int_mask_ff <= 8'h00;
         end else begin
            if (wr_acc && paddr == `ULM_OFS_CTRL) begin
               ctrl_ff <= {25'h0000000, pwdata[6:0]};
            end else if (mode_ff == ULM_WAKE && wake_cnt_ff == 4'h0) begin
               // Serial and UART mode selects self-clear so the device stays synchronous.
               ctrl_ff[`ULM_CTRL_SIX_PIN]   <= 1'b0;                          // R02
               ctrl_ff[`ULM_CTRL_THREE_PIN] <= 1'b0;
               ctrl_ff[`ULM_CTRL_UART_MODE] <= 1'b0;
            end
            if (wr_acc && paddr == `ULM_OFS_INT_MASK) begin
               int_mask_ff <= pwdata[7:0];
            end
         end
      end
   end

   // Sticky interrupt latch; a new event wins over the clear-on-read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_latch_ff <= 8'h00;
      end else if (clk_en) begin
         if (por) begin
            int_latch_ff <= 8'h00;
         end else begin
            int_latch_ff <= (latch_rd ? 8'h00 : int_latch_ff) | int_events;
         end
      end
   end

   // The pin is latched high by any unmasked event and falls on a latch read, a masking write or a power-on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_line_ff <= 1'b0;
      end else if (clk_en) begin
         int_line_ff <= |((int_latch_ff | int_events) & int_mask_ff);         // R07
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_acc) begin
         unique case (paddr)
            `ULM_OFS_CTRL:      prdata = ctrl_ff;
            `ULM_OFS_STATUS:    prdata = {24'h000000, uart_buf_en, sync_mode, clk_run,
                                          dir, 1'b0, mode_ff};
            `ULM_OFS_INT_LATCH: prdata = {24'h000000, int_latch_ff};
            `ULM_OFS_INT_MASK:  prdata = {24'h000000, int_mask_ff};
            default:            prdata = 32'h0000_0000;                       // R22
         endcase
      end
   end

   // ************************************************************
   // Chip-select power-down timer
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_low_cnt_ff <= 32'h0000_0000;
         cs_long_ff    <= 1'b0;
      end else if (clk_en) begin
         if (chip_select) begin
            cs_low_cnt_ff <= 32'h0000_0000;
            cs_long_ff    <= 1'b0;
         end else if (cs_low_cnt_ff >= 32'(PWRDN_CYC)) begin
            cs_long_ff <= 1'b1;                                               // R20
         end else begin
            cs_low_cnt_ff <= cs_low_cnt_ff + 32'h0000_0001;
         end
      end
   end

   // ************************************************************
   // Mode state machine
   // ************************************************************
   wire logic uart_req = ctrl_ff[`ULM_CTRL_UART_MODE] && ctrl_ff[`ULM_CTRL_TX_PATH] &&
                         ctrl_ff[`ULM_CTRL_RX_PATH];
   wire logic six_ok   = ctrl_ff[`ULM_CTRL_SIX_PIN] && !ctrl_ff[`ULM_CTRL_DDR4];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff      <= ULM_SYNC;
         drive_cnt_ff <= 3'h0;
         wake_cnt_ff  <= 4'h0;
      end else if (clk_en) begin
         if (por) begin
            // A power-on reset out of an alternate mode still restarts the clock
            // before DIR falls, so the link sees a normal turnaround.
            if (in_alt) begin
               mode_ff     <= ULM_WAKE;                                       // R20
               wake_cnt_ff <= 4'(`ULM_CLK_WAKE_CYC);                          // R25
            end
         end else begin
            unique case (mode_ff)
               ULM_SYNC: begin
                  if (uart_req) begin                                         // R16
                     mode_ff      <= ULM_UART_DRIVE;
                     drive_cnt_ff <= 3'(`ULM_UART_DRIVE_CYC);
                  end else if (six_ok) begin                                  // R04
                     mode_ff <= ULM_SIX_PIN;
                  end else if (ctrl_ff[`ULM_CTRL_THREE_PIN]) begin
                     mode_ff <= ULM_THREE_PIN;
                  end
               end
               ULM_UART_DRIVE: begin
                  // The first cycle is the turnaround; then five driven cycles.
                  drive_cnt_ff <= drive_cnt_ff - 3'h1;                        // R17
                  if (drive_cnt_ff == 3'h0) begin
                     mode_ff <= ULM_UART;                                     // R18
                  end
               end
               ULM_SIX_PIN, ULM_THREE_PIN, ULM_UART: begin
                  if (stp) begin                                              // R24
                     mode_ff     <= ULM_WAKE;
                     wake_cnt_ff <= 4'(`ULM_CLK_WAKE_CYC);
                  end
               end
               ULM_WAKE: begin
                  // DIR is held until the clock has settled again.
                  if (wake_cnt_ff != 4'h0) begin
                     wake_cnt_ff <= wake_cnt_ff - 4'h1;                       // R25
                  end else begin
                     mode_ff <= ULM_SYNC;                                     // R02
                  end
               end
               default: mode_ff <= ULM_SYNC;
            endcase
         end
      end
   end

   // ************************************************************
   // Pin mapping
   // ************************************************************
   always_comb begin
      nxt_bus.dout = 8'h00;
      nxt_bus.oe_n = 8'hFF;
      if (in_alt) begin
         nxt_bus.oe_n    = 8'h00;                                             // R11
         nxt_bus.dout[3] = int_line_ff;                                       // R07
      end
      unique case (mode_ff)
         ULM_SIX_PIN: begin
            nxt_bus.oe_n[2:0] = 3'b111;                                       // R05
            nxt_bus.dout[4]   = line_rx.plus_level;                           // R06
            nxt_bus.dout[5]   = line_rx.minus_level;
            nxt_bus.dout[6]   = line_rx.diff_level;
         end
         ULM_THREE_PIN: begin
            nxt_bus.oe_n[0] = 1'b1;
            nxt_bus.oe_n[1] = data_in[0];                                     // R09
            nxt_bus.oe_n[2] = data_in[0];                                     // R10
            nxt_bus.dout[1] = line_rx.diff_level;
            nxt_bus.dout[2] = line_rx.plus_level == 1'b0 && line_rx.minus_level == 1'b0;
         end
         ULM_UART_DRIVE: begin
            // The drive period pulls the link's DATA0 input high for slow links.
            if (drive_cnt_ff == 3'(`ULM_UART_DRIVE_CYC)) begin
               nxt_bus.oe_n = 8'hFF;
            end else begin
               nxt_bus.dout[0] = 1'b1;                                        // R17
            end
         end
         ULM_UART: begin
            nxt_bus.oe_n[0] = 1'b1;
            nxt_bus.dout[1] = line_rx.plus_level;                             // R12
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_bus <= '{dout: 8'h00, oe_n: 8'hFF};
      end else if (clk_en) begin
         data_bus <= nxt_bus;
      end
   end

   // ************************************************************
   // Line drive and control outputs
   // ************************************************************
   assign dir          = in_alt;                                              // R23
   assign sync_mode    = (mode_ff == ULM_SYNC);
   assign uart_buf_en  = (mode_ff == ULM_UART);                               // R18
   assign uart_dm_out  = uart_buf_en ? data_in[0] : 1'b1;                     // R12
   assign tx_enable    = (mode_ff == ULM_SIX_PIN || mode_ff == ULM_THREE_PIN) && data_in[0];
   assign tx_diff_data = tx_enable && data_in[1];                             // R05
   assign serial_tx_single_ended_zero       = tx_enable && data_in[2];
   // The clock stops in six-pin, three-pin and UART modes unless software asked otherwise.
   assign clk_run      = !(mode_ff == ULM_SIX_PIN || mode_ff == ULM_THREE_PIN ||
                           mode_ff == ULM_UART) || ctrl_ff[`ULM_CTRL_KEEP_CLK]; // R19

endmodule : ulm_alt_modes

// *** ulm_alt_modes_asserts.sv ***
/* Checker of the alternate-mode pin logic, bound to its top module.
   Assumes clk_en stays high and the APB master waits for pready. */
`timescale 1ns/1ps
module ulm_alt_modes_chk
   import ulm_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  prdata,
   input wire logic         pslverr,
   input wire logic         stp,
   input wire logic         chip_select,
   input wire logic [7:0]   data_in,
   input wire ulm_bus_t     data_bus,
   input wire logic         dir,
   input wire logic         clk_run,
   input wire logic         sync_mode,
   input wire logic         uart_buf_en,
   input wire ulm_line_rx_t line_rx,
   input wire logic         uart_dm_out
);
   // ******************************
   // Properties
   // ******************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_dir_alt_mode: assert property (!sync_mode |-> dir)
      else $error("dir low outside sync mode");
   a_uart_pins: assert property (uart_buf_en |-> data_bus.dout[7:4] == 4'h0 &&
      !data_bus.dout[2] && data_bus.oe_n[7:1] == 7'h00) else $error("uart pins wrong");
   a_uart_dm_pass: assert property (uart_buf_en |-> uart_dm_out == data_in[0])
      else $error("DATA0 not passed to DM");
   a_uart_rx_pass: assert property (uart_buf_en && $past(uart_buf_en)
      |-> data_bus.dout[1] == $past(line_rx.plus_level)) else $error("DP not on DATA1");
   a_uart_drive: assert property ($rose(uart_buf_en) |-> $past(data_bus.oe_n, 5) == 8'hFF
      && $past(data_bus.oe_n[0], 4) == 1'b0 && $past(data_bus.oe_n[0]) == 1'b0
      && !data_bus.oe_n[0] && data_bus.dout[0]) else $error("uart drive period wrong");
   a_int_held: assert property (uart_buf_en && data_bus.dout[3] && !$past(psel, 2)
      && $past(chip_select, 3) |=> data_bus.dout[3]) else $error("interrupt line dropped");
   a_dir_bus_idle: assert property (!dir && !$past(dir) |-> data_bus.oe_n == 8'hFF)
      else $error("bus driven with dir low");
   a_stp_exit: assert property (uart_buf_en && stp |-> ##[1:10] sync_mode)
      else $error("no exit on stop");
   a_dir_after_clk: assert property ($fell(dir) |-> clk_run && $past(clk_run))
      else $error("dir fell with clock stopped");
   a_carkit_zero: assert property (psel && penable && !pwrite && paddr == 12'h010
      |-> prdata == 32'h0000_0000 && !pslverr) else $error("carkit offset not zero");
endmodule : ulm_alt_modes_chk

bind ulm_alt_modes ulm_alt_modes_chk ulm_alt_modes_chk_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pslverr, .stp, .chip_select, .data_in, .data_bus, .dir,
   .clk_run, .sync_mode, .uart_buf_en, .line_rx, .uart_dm_out);

// *** ulm_link_model.sv ***
/* Link-side model of the data pins: resolves device and link drive.
   Assumes the bench chooses which pins the link drives each cycle. */
`timescale 1ns/1ps
module ulm_link_model
   import ulm_pkg::*;
(
   input  wire logic     pclk,
   input  wire ulm_bus_t data_bus,
   input  wire logic [7:0] drv_en,
   input  wire logic [7:0] drv_val,
   output logic [7:0]    pins
);
   logic [7:0] float_ff = 8'h55;
   // Undriven pins toggle so that a stale level can never pass for data.
   always_ff @(posedge pclk) begin
      float_ff <= ~float_ff;
   end
   // The link drives each enabled pin only where the device has released it.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pins[i] = !data_bus.oe_n[i] ? data_bus.dout[i] : drv_en[i] ? drv_val[i] : float_ff[i];
      end
   end
endmodule : ulm_link_model

// *** ulm_alt_modes_tb.sv ***
/* Testbench of the alternate-mode pin logic: APB tasks and mode scenarios.
   Assumes the checker is bound and the link model sits on the data pins. */
`timescale 1ns/1ps
module ulm_alt_modes_tb
   import ulm_pkg::*;
;
   logic         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, chip_select = 1'b1;
   logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stp = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0, prdata, rd_data;
   logic [7:0]   int_events = 8'h00, drv_en = 8'h00, drv_val = 8'h00, data_in;
   logic         pready, pslverr, rd_err, dir, clk_run, sync_mode, uart_buf_en;
   logic         tx_enable, tx_diff_data, serial_tx_single_ended_zero, uart_dm_out;
   ulm_line_rx_t line_rx = '0;
   ulm_bus_t     data_bus;
   int           n_fail = 0, samples_checked = 0;
   always #25 pclk = ~pclk;
   ulm_alt_modes #(.PWRDN_CYC(20)) ulm_alt_modes_i (.pclk, .presetn, .clk_en, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stp, .chip_select,
      .data_in, .data_bus, .dir, .clk_run, .sync_mode, .uart_buf_en, .line_rx, .int_events,
      .tx_enable, .tx_diff_data, .serial_tx_single_ended_zero, .uart_dm_out);
   ulm_link_model ulm_link_model_i (.pclk, .data_bus, .drv_en, .drv_val, .pins(data_in));
   // ******************************
   // Tasks
   // ******************************
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t no pready", $time);
         end_sim();
      end
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_data, exp);
   endtask : rd
   task automatic wait_st(input logic [1:0] m, input logic [1:0] v);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (({uart_buf_en, sync_mode} & m) !== v && n < 60);
      if (({uart_buf_en, sync_mode} & m) !== v) begin
         n_fail++;
         $display("[FAIL] %0t mode wait timed out", $time);
         end_sim();
      end
   endtask : wait_st
   // ******************************
   // Scenarios
   // ******************************
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h60);
      rd(12'h010, 32'h0);
      apb(1'b1, 12'h010, 32'hFF);
      rd(12'h010, 32'h0);
      rd(12'h020, 32'h0);
      chk(rd_err, 1'b1);
      apb(1'b1, 12'h00C, 32'hFF);
      apb(1'b1, 12'h000, 32'h41);
      repeat (4) @(posedge pclk);
      chk({dir, sync_mode}, 2'b01);
      $display("test regs and ddr refusal done");
      drv_en  <= 8'h07;
      drv_val <= 8'h05;
      line_rx <= 3'b101;
      apb(1'b1, 12'h000, 32'h01);
      wait_st(2'b01, 2'b00);
      repeat (2) @(posedge pclk);
      chk({data_bus.dout[7:4], data_bus.oe_n[7:4], dir}, 9'b0101_0000_1);
      chk({tx_enable, tx_diff_data, serial_tx_single_ended_zero}, 3'b101);
      int_events <= 8'h04;
      @(posedge pclk);
      int_events <= 8'h00;
      repeat (3) @(posedge pclk);
      chk(data_bus.dout[3], 1'b1);
      stp <= 1'b1;
      wait_st(2'b01, 2'b01);
      stp <= 1'b0;
      rd(12'h008, 32'h4);
      $display("test six-pin done");
      drv_en  <= 8'h01;
      drv_val <= 8'h00;
      line_rx <= 3'b001;
      apb(1'b1, 12'h000, 32'h02);
      wait_st(2'b01, 2'b00);
      repeat (2) @(posedge pclk);
      chk({data_bus.oe_n[7:1], data_bus.dout[7:1]}, 14'b0000000_0000011);
      drv_en  <= 8'h07;
      drv_val <= 8'h03;
      repeat (3) @(posedge pclk);
      chk({data_bus.oe_n[2:1], tx_enable, tx_diff_data, serial_tx_single_ended_zero}, 5'b11110);
      stp <= 1'b1;
      wait_st(2'b01, 2'b01);
      stp <= 1'b0;
      $display("test three-pin done");
      // Speed, pull-down and termination setup lives outside this block.
      drv_en  <= 8'h01;
      drv_val <= 8'h01;
      apb(1'b1, 12'h000, 32'h30);
      repeat (3) @(posedge pclk);
      chk(sync_mode, 1'b1);
      apb(1'b1, 12'h000, 32'h38);
      wait_st(2'b10, 2'b10);
      chk({clk_run, data_bus.dout[2], data_bus.dout[7:4], uart_dm_out}, 7'h01);
      drv_val <= 8'h00;
      line_rx <= 3'b100;
      repeat (2) @(posedge pclk);
      chk({uart_dm_out, data_bus.dout[1]}, 2'b01);
      int_events <= 8'h10;
      @(posedge pclk);
      int_events <= 8'h00;
      repeat (3) @(posedge pclk);
      chk(data_bus.dout[3], 1'b1);
      stp <= 1'b1;
      wait_st(2'b01, 2'b01);
      stp <= 1'b0;
      rd(12'h008, 32'h10);
      apb(1'b1, 12'h000, 32'h34);
      apb(1'b1, 12'h000, 32'h3C);
      wait_st(2'b10, 2'b10);
      chk(clk_run, 1'b1);
      chip_select <= 1'b0;
      repeat (25) @(posedge pclk);
      chip_select <= 1'b1;
      wait_st(2'b01, 2'b01);
      rd(12'h000, 32'h0);
      $display("test uart done");
      end_sim();
   end
endmodule : ulm_alt_modes_tb
